/* File: rtl/cxd_core.sv */
/*
 coprocessor instruction decode and execution control: conditional
 execution, trap decisions, control-register transfers, flag loading,
 load/store address generation for emulation hints, event interrupt.
 assumes the pipeline presents one instruction with a valid strobe and
 flags, and accepts done/trap pulses; all inputs are on clk.
*/
// Implementation choices: the register offsets and the strobed register port.
`timescale 1ns/10ps
`default_nettype none
module cxd_core
   import cxd_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        instr_valid,
   input  wire logic [31:0] instr,
   input  wire logic [31:0] instr_addr,
   input  wire logic [3:0]  flags_in,
   input  wire logic [31:0] core_reg_data,
   input  wire logic [31:0] base_reg_data,
   input  wire logic [3:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic [31:0]      reg_rdata,
   output logic             done,
   output logic             undef_trap,
   output logic             coproc_absent_line,
   output logic             coproc_busy_line,
   output logic             flags_we,
   output logic [3:0]       flags_out,
   output logic             core_reg_we,
   output logic [3:0]       core_reg_idx,
   output logic [31:0]      core_reg_wdata,
   output logic             base_we,
   output logic [31:0]      base_wdata,
   output logic [31:0]      xfer_addr,
   output logic             xfer_long,
   output logic             irq
);
   import cxd_pkg::*;

   cxd_state_e state;
   logic [1:0]  int_cnt;
   logic [31:0] cfg_reg;
   logic [3:0]  status;
   logic [3:0]  mask;
   logic        trap_en;
   logic [31:0] last_instr;
   logic [15:0] exec_count;
   logic        hold_l;
   logic [3:0]  hold_rd;
   logic [31:0] hold_wd;

   // decode
   logic        cond_ok;
   logic        is_xfer;
   logic        is_ldst;
   logic        is_dataop;
   logic        is_undef;
   logic        is_ctrl;
   logic [3:0]  c;
   logic [3:0]  fl;
   logic [31:0] ofs;
   logic [31:0] moved;

   assign fl = flags_in; // N Z C V
   assign c  = instr[COND_HI:COND_LO];

   always_comb begin
      case (c)
         4'h0: cond_ok = fl[2];
         4'h1: cond_ok = !fl[2];
         4'h2: cond_ok = fl[1];
         4'h3: cond_ok = !fl[1];
         4'h4: cond_ok = fl[3];
         4'h5: cond_ok = !fl[3];
         4'h6: cond_ok = fl[0];
         4'h7: cond_ok = !fl[0];
         4'h8: cond_ok = fl[1] && !fl[2];
         4'h9: cond_ok = !fl[1] || fl[2];
         4'ha: cond_ok = fl[3] == fl[0];
         4'hb: cond_ok = fl[3] != fl[0];
         4'hc: cond_ok = !fl[2] && (fl[3] == fl[0]);
         4'hd: cond_ok = fl[2] || (fl[3] != fl[0]);
         4'he: cond_ok = 1'b1;
         default: cond_ok = 1'b0;
      endcase
   end

   assign is_xfer   = (instr[27:24] == 4'he) && instr[4];
   assign is_dataop = (instr[27:24] == 4'he) && !instr[4];
   assign is_ldst   = (instr[27:25] == 3'h6);
   assign is_undef  = (instr[27:25] == 3'h3) && instr[4];
   // only number 15 answers, and only to transfers
   assign is_ctrl   = is_xfer && (instr[NUM_HI:NUM_LO] == CTRL_CP);

   // word offset scaled to bytes for the emulation address
   assign ofs = {22'h0, instr[OFS_HI:OFS_LO], 2'h0};
   assign moved = instr[BIT_U] ? base_reg_data + ofs
                               : base_reg_data - ofs;

   // sequencer: one fetch then three internal cycles for control moves
   always_ff @(posedge clk) begin
      if (rst) begin
         state   <= CXD_IDLE;
         int_cnt <= 2'h0;
      end else begin
         case (state)
            CXD_IDLE:
               if (instr_valid && cond_ok && is_ctrl && trap_en) begin
                  state <= CXD_FETCH;
               end
            CXD_FETCH: begin
               state   <= CXD_INT;
               int_cnt <= 2'(INTERNAL_CYC - 1);
            end
            CXD_INT:
               if (int_cnt == 2'h0) begin
                  state <= CXD_IDLE;
               end else begin
                  int_cnt <= int_cnt - 2'h1;
               end
            default: state <= CXD_IDLE;
         endcase
      end
   end

   // latch the transfer at acceptance; hold while the sequence runs
   always_ff @(posedge clk) begin
      if (rst) begin
         hold_l  <= 1'b0;
         hold_rd <= 4'h0;
         hold_wd <= 32'h0;
      end else if (state == CXD_IDLE && instr_valid) begin
         hold_l  <= instr[BIT_L];
         hold_rd <= instr[RD_HI:RD_LO];
         hold_wd <= (instr[RD_HI:RD_LO] == REG_PC)
                    ? instr_addr + PC_SRC_OFS : core_reg_data;
      end
   end

   // pipeline answers: done, trap, core register and flag writes
   always_ff @(posedge clk) begin
      if (rst) begin
         done           <= 1'b0;
         undef_trap     <= 1'b0;
         flags_we       <= 1'b0;
         flags_out      <= 4'h0;
         core_reg_we    <= 1'b0;
         core_reg_idx   <= 4'h0;
         core_reg_wdata <= 32'h0;
         cfg_reg        <= RST_CFG;
      end else begin
         done        <= 1'b0;
         undef_trap  <= 1'b0;
         flags_we    <= 1'b0;
         core_reg_we <= 1'b0;
         if (state == CXD_IDLE && instr_valid) begin
            if (!cond_ok) begin
               done <= 1'b1;
            end else if (is_undef || is_ldst || is_dataop) begin
               undef_trap <= 1'b1;
            end else if (is_xfer && (!is_ctrl || !trap_en)) begin
               undef_trap <= 1'b1;
            end else if (!is_xfer) begin
               done <= 1'b1;
            end
         end
         if (state == CXD_INT && int_cnt == 2'h0) begin
            done <= 1'b1;
            if (hold_l) begin
               if (hold_rd == REG_PC) begin
                  flags_we  <= 1'b1;
                  flags_out <= cfg_reg[31:28];
               end else begin
                  core_reg_we    <= 1'b1;
                  core_reg_idx   <= hold_rd;
                  core_reg_wdata <= cfg_reg;
               end
            end else if (reg_wr && reg_addr == A_CFG) begin
               cfg_reg <= reg_wdata;
            end else begin
               cfg_reg <= hold_wd;
            end
         end else if (reg_wr && reg_addr == A_CFG) begin
            cfg_reg <= reg_wdata;
         end
      end
   end

   // hints for the emulation handler on load/store traps
   always_ff @(posedge clk) begin
      if (rst) begin
         base_we    <= 1'b0;
         base_wdata <= 32'h0;
         xfer_addr  <= 32'h0;
         xfer_long  <= 1'b0;
      end else begin
         base_we <= 1'b0;
         if (state == CXD_IDLE && instr_valid && cond_ok && is_ldst) begin
            xfer_addr  <= instr[BIT_P] ? moved : base_reg_data;
            xfer_long  <= instr[BIT_N];
            base_we    <= instr[BIT_W];
            base_wdata <= moved;
         end
      end
   end

   // refusal lines: the control coprocessor declines all but its transfers
   always_ff @(posedge clk) begin
      if (rst) begin
         coproc_absent_line <= 1'b1;
         coproc_busy_line   <= 1'b1;
      end else begin
         coproc_absent_line <= !(instr_valid && is_ctrl);
         coproc_busy_line   <= !(instr_valid && is_ctrl);
      end
   end

   // status: 0 trap, 1 control move done, 2 skipped, 3 base write-back
   always_ff @(posedge clk) begin
      if (rst) begin
         status <= 4'h0;
      end else begin
         // set wins over the write-one clear
         status <= (status & ~((reg_wr && reg_addr == A_STATUS)
                               ? reg_wdata[3:0] : 4'h0))
                   | {base_we, state == CXD_IDLE && instr_valid && !cond_ok,
                      state == CXD_INT && int_cnt == 2'h0, undef_trap};
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         mask    <= RST_MASK;
         trap_en <= 1'b1;
      end else if (reg_wr) begin
         if (reg_addr == A_MASK) mask <= reg_wdata[3:0];
         // ctrl bit 0 clear forces every transfer to trap for emulation
         if (reg_addr == A_CTRL) trap_en <= reg_wdata[0];
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         last_instr <= 32'h0;
         exec_count <= 16'h0;
      end else if (state == CXD_IDLE && instr_valid) begin
         last_instr <= instr;
         exec_count <= exec_count + 16'h1;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         irq <= 1'b0;
      end else begin
         irq <= |(status & mask);
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         reg_rdata <= 32'h0;
      end else if (reg_rd) begin
         case (reg_addr)
            A_STATUS: reg_rdata <= {28'h0, status};
            A_MASK:   reg_rdata <= {28'h0, mask};
            A_CTRL:   reg_rdata <= {31'h0, trap_en};
            A_LAST:   reg_rdata <= last_instr;
            A_CFG:    reg_rdata <= cfg_reg;
            A_COUNT:  reg_rdata <= {16'h0, exec_count};
            default:  reg_rdata <= 32'h0;
         endcase
      end else begin
         reg_rdata <= 32'h0;
      end
   end

   AST_SKIP: assert property (@(posedge clk) disable iff (rst)
      state == CXD_IDLE && instr_valid && !cond_ok |=> done && !undef_trap)
      else $error("failed condition not skipped");
   AST_FOREIGN: assert property (@(posedge clk) disable iff (rst)
      state == CXD_IDLE && instr_valid && cond_ok && is_xfer
      && instr[NUM_HI:NUM_LO] != CTRL_CP |=> undef_trap)
      else $error("foreign transfer did not trap");
   AST_LDST: assert property (@(posedge clk) disable iff (rst)
      state == CXD_IDLE && instr_valid && cond_ok && is_ldst
      |=> undef_trap && !done)
      else $error("load store did not trap");
   AST_UNDEF: assert property (@(posedge clk) disable iff (rst)
      state == CXD_IDLE && instr_valid && cond_ok && is_undef |=> undef_trap)
      else $error("undefined encoding did not trap");
   AST_CYCLES: assert property (@(posedge clk) disable iff (rst)
      state == CXD_IDLE && instr_valid && cond_ok && is_ctrl && trap_en
      |=> !done [*4] ##1 done)
      else $error("control move cycle count wrong");
   AST_FLAGS: assert property (@(posedge clk) disable iff (rst)
      flags_we |-> flags_out == $past(cfg_reg[31:28]) && !core_reg_we)
      else $error("flags not from bits 31 to 28");
   AST_WB: assert property (@(posedge clk) disable iff (rst)
      state == CXD_IDLE && instr_valid && cond_ok && is_ldst
      |=> base_we == $past(instr[BIT_W]))
      else $error("write back bit ignored");
   AST_NOMOD: assert property (@(posedge clk) disable iff (rst)
      state == CXD_IDLE && instr_valid && !cond_ok && !reg_wr
      |=> $stable(cfg_reg) && !core_reg_we && !flags_we)
      else $error("skipped move changed state");
   AST_DECLINE: assert property (@(posedge clk) disable iff (rst)
      instr_valid && !is_ctrl |=> coproc_absent_line && coproc_busy_line)
      else $error("foreign instruction accepted");
   AST_PCSRC: assert property (@(posedge clk) disable iff (rst)
      state == CXD_IDLE && instr_valid && instr[RD_HI:RD_LO] == REG_PC
      |=> hold_wd == $past(instr_addr) + PC_SRC_OFS)
      else $error("pc source not address plus twelve");
   AST_TO_CP: assert property (@(posedge clk) disable iff (rst)
      state == CXD_INT && int_cnt == 2'h0 && !hold_l
      |=> !flags_we && !core_reg_we)
      else $error("core to coprocessor move wrote the core");
   AST_LONG: assert property (@(posedge clk) disable iff (rst)
      state == CXD_IDLE && instr_valid && cond_ok && is_ldst
      |=> xfer_long == $past(instr[BIT_N]))
      else $error("length bit not passed on");
   AST_POST: assert property (@(posedge clk) disable iff (rst)
      state == CXD_IDLE && instr_valid && cond_ok && is_ldst && !instr[BIT_P]
      |=> xfer_addr == $past(base_reg_data))
      else $error("post index address not the base");
endmodule
`default_nettype wire

/* File: rtl/cxd_pkg.sv */
/*
 coprocessor transfer decode package: instruction field positions,
 control coprocessor and pc numbers, cycle counts and register map of the control port.
 assumes a 32-bit instruction word in the classic coprocessor layout.
*/
package cxd_pkg;
   localparam int COND_HI      = 31;
   localparam int COND_LO      = 28;
   localparam int NUM_HI       = 11;  // coproc_number_field
   localparam int NUM_LO       = 8;
   localparam int RD_HI        = 15;
   localparam int RD_LO        = 12;
   localparam int RN_HI        = 19;
   localparam int RN_LO        = 16;
   localparam int CRN_HI       = 19;  // coproc_first_reg_field
   localparam int CRN_LO       = 16;
   localparam int CRM_HI       = 3;   // coproc_second_reg_field
   localparam int CRM_LO       = 0;
   localparam int OPC_HI       = 23;  // coproc_opcode_field (transfer)
   localparam int OPC_LO       = 21;
   localparam int INFO_HI      = 7;
   localparam int INFO_LO      = 5;
   localparam int BIT_L        = 20;
   localparam int BIT_W        = 21;
   localparam int BIT_N        = 22;
   localparam int BIT_U        = 23;
   localparam int BIT_P        = 24;
   localparam int OFS_HI       = 7;
   localparam int OFS_LO       = 0;
   localparam int OFS_SHIFT    = 2;
   localparam logic [3:0] CTRL_CP    = 4'hf;
   localparam logic [3:0] REG_PC     = 4'hf;
   localparam logic [31:0] PC_SRC_OFS = 32'h0000000c;
   localparam int FETCH_CYC    = 1;
   localparam int INTERNAL_CYC = 3;
   // register port map
   localparam logic [3:0] A_STATUS = 4'h0;
   localparam logic [3:0] A_MASK   = 4'h1;
   localparam logic [3:0] A_CTRL   = 4'h2;
   localparam logic [3:0] A_LAST   = 4'h3;
   localparam logic [3:0] A_CFG    = 4'h4;
   localparam logic [3:0] A_COUNT  = 4'h5;
   localparam logic [3:0] RST_MASK = 4'h0;
   localparam logic [31:0] RST_CFG = 32'h00000000;
   typedef enum logic [1:0] {CXD_IDLE, CXD_FETCH, CXD_INT} cxd_state_e;
endpackage

/* File: sim/cxd_pipe_model.sv */
/*
 pipeline-side partner: status flags and core register file that the
 decode block reads and updates.
 assumes one clock clk and a synchronous active-high rst.
*/
`timescale 1ns/10ps
`default_nettype none
module cxd_pipe_model (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        flags_we,
   input  wire logic [3:0]  flags_out,
   input  wire logic        core_reg_we,
   input  wire logic [3:0]  core_reg_idx,
   input  wire logic [31:0] core_reg_wdata,
   input  wire logic [3:0]  rd_idx,
   output logic [3:0]       flags_in,
   output logic [31:0]      core_reg_data,
   output logic [31:0]      pc_value
);
   logic [31:0] regs [16];

   // only the four flags move; r15 is left to the register file
   always_ff @(posedge clk) begin
      if (rst) begin
         flags_in <= 4'h0;
      end else if (flags_we) begin
         flags_in <= flags_out;
      end
   end

   // distinct reset pattern so a wrong register index shows up
   always_ff @(posedge clk) begin
      if (rst) begin
         for (int i = 0; i < 16; i++) begin
            regs[i] <= {28'h5a5a5a0, 4'(i)};
         end
      end else if (core_reg_we) begin
         regs[core_reg_idx] <= core_reg_wdata;
      end
   end

   assign core_reg_data = regs[rd_idx];
   assign pc_value      = regs[15];
endmodule
`default_nettype wire

/* File: sim/tb_coproc_transfer_decode_trap.sv */
/*
 testbench of the coprocessor decode block: control moves, traps,
 condition skips, load/store hints and the register port.
 assumes cxd_pkg, cxd_core and cxd_pipe_model are compiled first.
*/
`timescale 1ns/10ps
`default_nettype none
module tb_coproc_transfer_decode_trap;
   import cxd_pkg::*;
   logic        clk, rst, instr_valid, reg_wr, reg_rd, ab_seen;
   logic        done, undef_trap, coproc_absent_line, coproc_busy_line;
   logic        flags_we, core_reg_we, base_we, xfer_long, irq;
   logic [3:0]  flags_in, reg_addr, flags_out, core_reg_idx;
   logic [31:0] instr, instr_addr, base_reg_data, reg_wdata, reg_rdata;
   logic [31:0] core_reg_data, core_reg_wdata, base_wdata, xfer_addr;
   logic [31:0] pc_value;
   int          failures, total_checks, cycles;

   cxd_core u_dut (.clk, .rst, .instr_valid, .instr, .instr_addr,
      .flags_in, .core_reg_data, .base_reg_data, .reg_addr, .reg_wdata,
      .reg_wr, .reg_rd, .reg_rdata, .done, .undef_trap,
      .coproc_absent_line, .coproc_busy_line, .flags_we, .flags_out,
      .core_reg_we, .core_reg_idx, .core_reg_wdata, .base_we,
      .base_wdata, .xfer_addr, .xfer_long, .irq);

   cxd_pipe_model u_pipe (.clk, .rst, .flags_we, .flags_out, .core_reg_we,
      .core_reg_idx, .core_reg_wdata, .rd_idx(instr[15:12]), .flags_in,
      .core_reg_data, .pc_value);

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   task automatic give_verdict();
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // a hang ends the run as a failure
   initial begin
      cycles = 0;
      forever begin
         @(posedge clk);
         cycles++;
         if (cycles == 3000) begin
            failures++;
            give_verdict();
         end
      end
   end

   task automatic chk(input logic ok, input string msg);
      total_checks++;
      if (ok !== 1'b1) begin
         failures++;
         $display("mismatch %0t %s", $time, msg);
      end
   endtask

   function automatic logic [31:0] rt(input logic [3:0] c, input logic l,
                                      input logic [3:0] cp,
                                      input logic [3:0] rd);
      return {c, 4'he, 3'h1, l, 4'h2, rd, cp, 3'h0, 1'b1, 4'h3};
   endfunction

   // n counts edges from the offer up to the answer cycle
   task automatic offer(input logic [31:0] w, input logic [31:0] a,
                        output int n);
      @(posedge clk);
      instr       <= w;
      instr_addr  <= a;
      instr_valid <= 1'b1;
      @(posedge clk);
      instr_valid <= 1'b0;
      n = 1;
      #1;
      ab_seen = coproc_absent_line | coproc_busy_line;
      while (done !== 1'b1 && undef_trap !== 1'b1 && n < 20) begin
         @(posedge clk);
         #1;
         n++;
      end
   endtask

   task automatic reg_read(input logic [3:0] a, input logic [31:0] e);
      @(posedge clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      chk(reg_rdata === e, "register read value");
   endtask

   task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask

   task automatic t_reset();
      #1;
      chk(coproc_absent_line === 1'b1 && coproc_busy_line === 1'b1 &&
          done === 1'b0 && irq === 1'b0, "reset outputs");
      reg_read(A_MASK, 32'h0);
      reg_read(A_CFG, RST_CFG);
   endtask

   task automatic t_ctrl();
      int n;
      offer(rt(4'he, 1'b0, CTRL_CP, REG_PC), 32'ha000_0ff4, n);
      chk(n == FETCH_CYC + INTERNAL_CYC + 1, "control cycle count");
      chk(ab_seen === 1'b0 && done === 1'b1, "control not taken");
      reg_read(A_CFG, 32'ha000_1000);
      offer(rt(4'he, 1'b1, CTRL_CP, REG_PC), 32'h0, n);
      chk(flags_we === 1'b1 && flags_out === 4'ha, "flags load");
      chk(core_reg_we === 1'b0, "pc written by flag load");
      offer(rt(4'he, 1'b0, CTRL_CP, 4'h3), 32'h0, n);
      reg_read(A_CFG, 32'h5a5a5a03);
      offer(rt(4'he, 1'b1, CTRL_CP, 4'h7), 32'h0, n);
      chk(core_reg_we === 1'b1 && core_reg_idx === 4'h7 &&
          core_reg_wdata === 32'h5a5a5a03, "read into core");
      chk(pc_value === 32'h5a5a5a0f, "pc disturbed");
      reg_read(A_STATUS, 32'h2);
   endtask

   // flags hold z clear, so an equal-condition move must be skipped
   task automatic t_skip();
      int n;
      offer(rt(4'h0, 1'b0, CTRL_CP, 4'h4), 32'h0, n);
      chk(n == 1 && done === 1'b1 && undef_trap === 1'b0, "skip");
      chk(core_reg_we === 1'b0 && flags_we === 1'b0, "skip wrote");
      reg_read(A_CFG, 32'h5a5a5a03);
   endtask

   task automatic t_foreign();
      int n;
      for (int l = 0; l < 2; l++) begin
         offer(rt(4'he, 1'(l), 4'h3, 4'h2), 32'h0, n);
         chk(undef_trap === 1'b1 && done === 1'b0 && n == 1, "no trap");
         chk(ab_seen === 1'b1 && core_reg_we === 1'b0, "wrong unit");
      end
   endtask

   task automatic t_traps();
      int          n;
      logic [31:0] w [4] = '{32'he600_0010, 32'hee00_0100,
                             32'hed80_0f00, 32'hed90_0f00};
      for (int i = 0; i < 4; i++) begin
         offer(w[i], 32'h0, n);
         chk(undef_trap === 1'b1 && done === 1'b0, "class kept");
         chk(ab_seen === 1'b1, "undefined accepted");
      end
      offer({4'hf, w[0][27:0]}, 32'h0, n);
      chk(undef_trap === 1'b0 && done === 1'b1, "failed cond trap");
   endtask

   task automatic t_ldst();
      int n;
      offer({4'he, 3'b110, 4'b1011, 1'b1, 12'h215, 8'h05}, 32'h0, n);
      chk(undef_trap === 1'b1 && base_we === 1'b1, "write-back");
      chk(base_wdata === 32'h0fec && xfer_addr === 32'h0fec, "pre down");
      chk(xfer_long === 1'b1, "long option");
      offer({4'he, 3'b110, 4'b0100, 1'b0, 12'h215, 8'hff}, 32'h0, n);
      chk(base_we === 1'b0 && xfer_addr === 32'h1000, "post index");
      chk(xfer_long === 1'b0, "short option");
   endtask

   task automatic t_regs();
      reg_read(A_COUNT, 32'he);
      reg_read(A_LAST, 32'hec8215ff);
      reg_read(A_STATUS, 32'hf);
      reg_read(4'hf, 32'h0);
      reg_write(A_MASK, 32'h1);
      reg_read(A_MASK, 32'h1);
      #1;
      chk(irq === 1'b1, "irq not raised");
      reg_write(A_STATUS, 32'h1);
      repeat (2) @(posedge clk);
      #1;
      chk(irq === 1'b0, "irq not cleared");
      reg_read(A_STATUS, 32'he);
   endtask

   // ctrl bit 0 clear: even a control move goes to emulation
   task automatic t_emul();
      int n;
      reg_read(A_CTRL, 32'h1);
      reg_write(A_CTRL, 32'h0);
      offer(rt(4'he, 1'b0, CTRL_CP, 4'h3), 32'h0, n);
      chk(undef_trap === 1'b1 && done === 1'b0 && n == 1, "move not trapped");
      reg_read(A_CTRL, 32'h0);
      chk(irq === 1'b1, "trap event lost");
      reg_write(A_CTRL, 32'h1);
   endtask

   initial begin
      failures      = 0;
      total_checks  = 0;
      rst           = 1'b1;
      instr_valid   = 1'b0;
      instr         = 32'h0;
      instr_addr    = 32'h0;
      base_reg_data = 32'h1000;
      reg_addr      = 4'h0;
      reg_wdata     = 32'h0;
      reg_wr        = 1'b0;
      reg_rd        = 1'b0;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      t_reset();
      t_ctrl();
      t_skip();
      t_foreign();
      t_traps();
      t_ldst();
      t_regs();
      t_emul();
      give_verdict();
   end
endmodule
`default_nettype wire
